// ==== pkg/srqp_pkg.sv ====
// Notes on behaviour
// - questionable word: only bit 5 frequency and bit 9 limit summary are driven
// - questionable bit 9 follows the limit summary, set while any enabled limit event bit is latched
// - questionable bit 15 always reads zero
// - limit word even bits 0,2,4,6: traces 1 to 4 below their limit line
// - limit word odd bits 1,3,5,7: traces 1 to 4 above limit; bits above 7 unused
// - questionable word readable as live condition and as latched event view
// - service request when status byte bits 2,3,4,5,7 set and enabled
// - status byte bits 2 to 5 each summarise a lower register, error queue or output buffer
// - enable parts gate which register bits reach their summary bit
// - opc enabled in both enables raises service request once settings finish
// - serial poll returns the same status byte as the status byte query
// - parallel poll: enable AND status byte incl bit 6, OR, XOR with sense, own line
// - up to eight devices answer one parallel poll, each on its own line
// - individual status query returns the ORed parallel poll bit
// - every register part query returns its bit pattern as one number
// - each error appends a queue entry unless the queue is full; each error query pops one
// - empty error queue answers code 0, no error
// - status preset clears enables, ptr filters to ones, ntr filters to zero
// - clear status clears event parts, status byte except MAV bit 4, event status, error queue
package srqp_pkg;

  // ***********************
  // bit positions
  // ***********************
  localparam int QUES_FREQ_BIT  = 5;
  localparam int QUES_LIMIT_BIT = 9;
  localparam int STB_ERRQ_BIT   = 2;
  localparam int STB_QUES_BIT   = 3;
  localparam int STB_MAV_BIT    = 4;
  localparam int STB_ESB_BIT    = 5;
  localparam int STB_MSS_BIT    = 6;
  localparam int ESR_OPC_BIT    = 0;
  localparam int NUM_TRACES     = 4;

  // ***********************
  // masks and reset values
  // ***********************
  localparam logic [7:0]  STB_SRQ_MASK   = 8'hbc;
  localparam logic [15:0] LIMIT_USED     = 16'h00ff;
  localparam logic [15:0] ENABLE_PRESET  = 16'h0000;
  localparam logic [15:0] PTR_PRESET     = 16'hffff;
  localparam logic [15:0] NTR_PRESET     = 16'h0000;
  localparam logic [7:0]  ESR_RESET      = 8'h80;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [15:0] NO_ERROR_CODE  = 16'h0000;
  localparam int          ERRQ_DEPTH_DEF = 8;

  // ***********************
  // commands
  // ***********************
  typedef enum logic [4:0] {
    CMD_NOP,
    CMD_QUES_COND_RD,
    CMD_QUES_EVT_RD,
    CMD_QUES_EN_RD,
    CMD_QUES_EN_WR,
    CMD_QUES_PTR_WR,
    CMD_QUES_NTR_WR,
    CMD_LIM_COND_RD,
    CMD_LIM_EVT_RD,
    CMD_LIM_EN_RD,
    CMD_LIM_EN_WR,
    CMD_LIM_PTR_WR,
    CMD_LIM_NTR_WR,
    CMD_SRE_RD,
    CMD_SRE_WR,
    CMD_ESE_RD,
    CMD_ESE_WR,
    CMD_ESR_RD,
    CMD_STB_RD,
    CMD_PPE_RD,
    CMD_PPE_WR,
    CMD_PP_CFG_WR,
    CMD_IST_RD,
    CMD_ERR_RD,
    CMD_CLS,
    CMD_STAT_PRESET,
    CMD_OPC
  } srqp_cmd_op_t;

  typedef struct packed {
    srqp_cmd_op_t op;
    logic [15:0]  data;
  } srqp_cmd_t;

  // parallel poll configuration: data[4] enable, data[3] sense, data[2:0] line
  typedef struct packed {
    logic       enable;
    logic       sense;
    logic [2:0] line;
  } srqp_pp_cfg_t;

  typedef struct packed {
    logic                  freqQuestionable;
    logic [NUM_TRACES-1:0] traceBelow;
    logic [NUM_TRACES-1:0] traceAbove;
    logic                  messageAvailable;
    logic                  settingsDone;
    logic [7:1]            esrEvents;
  } srqp_status_in_t;

endpackage

// ==== src/srqp_status_core.sv ====
`timescale 1ns/10ps
module srqp_status_core #(
  parameter int ERRQ_DEPTH = srqp_pkg::ERRQ_DEPTH_DEF
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic                     clkEn,
  input  wire logic                     cmdValid,
  input  wire srqp_pkg::srqp_cmd_t      cmd,
  input  wire srqp_pkg::srqp_status_in_t statIn,
  input  wire logic                     errPush,
  input  wire logic [15:0]              errCode,
  input  wire logic                     serialPoll,
  input  wire logic                     parallelPoll,
  output logic                          respValid,
  output logic [15:0]                   respData,
  output logic                          srq,
  output logic                          spValid,
  output logic [7:0]                    spByte,
  output logic [7:0]                    ppDataOut,
  output logic [7:0]                    ppDataOe,
  output logic                          errQueueFull
);

  localparam int CNT_W = $clog2(ERRQ_DEPTH + 1);
  localparam int PTR_W = (ERRQ_DEPTH > 1) ? $clog2(ERRQ_DEPTH) : 1;

  // ***********************
  // state
  // ***********************
  typedef struct packed {
    logic [15:0]                 quesCond;
    logic [15:0]                 quesEvt;
    logic [15:0]                 quesEn;
    logic [15:0]                 quesPtr;
    logic [15:0]                 quesNtr;
    logic [15:0]                 limCond;
    logic [15:0]                 limEvt;
    logic [15:0]                 limEn;
    logic [15:0]                 limPtr;
    logic [15:0]                 limNtr;
    logic [7:0]                  sre;
    logic [7:0]                  ese;
    logic [7:0]                  esr;
    logic [7:0]                  ppe;
    srqp_pkg::srqp_pp_cfg_t      ppCfg;
    logic [7:0]                  stb;
    logic                        opcPending;
    logic [ERRQ_DEPTH-1:0][15:0] errMem;
    logic [PTR_W-1:0]            errRd;
    logic [PTR_W-1:0]            errWr;
    logic [CNT_W-1:0]            errCnt;
    logic                        errFull;
    logic                        respValid;
    logic [15:0]                 respData;
    logic                        srq;
    logic                        spValid;
    logic [7:0]                  spByte;
    logic [7:0]                  ppDataOut;
    logic [7:0]                  ppDataOe;
  } srqp_core_state_t;

  srqp_core_state_t state_r;
  srqp_core_state_t state_nxt;

  // ***********************
  // helpers
  // ***********************
  // read clears, but a transition in the same cycle still lands
  function automatic logic [15:0] evtUpdate(
    input logic [15:0] evt,
    input logic [15:0] condNew,
    input logic [15:0] condOld,
    input logic [15:0] ptr,
    input logic [15:0] ntr,
    input logic        clr
  );
    logic [15:0] hits;
    hits = (condNew & ~condOld & ptr) | (~condNew & condOld & ntr);
    return (clr ? 16'h0000 : evt) | hits;
  endfunction

  function automatic logic [PTR_W-1:0] ptrInc(input logic [PTR_W-1:0] p);
    if (p == PTR_W'(ERRQ_DEPTH - 1)) begin
      return '0;
    end
    return p + PTR_W'(1);
  endfunction

  // ***********************
  // next state
  // ***********************
  logic [15:0] quesCondNew;
  logic [15:0] limCondNew;
  logic        limSummary;
  logic        quesSummary;
  logic        esbSummary;
  logic [7:0]  stbLow;
  logic        mss;
  logic        ist;
  logic        errEmpty;
  logic        isCls;
  logic        isPreset;
  logic        doPush;
  logic        doPop;

  always_comb begin
    state_nxt = state_r;
    isCls     = cmdValid && (cmd.op == srqp_pkg::CMD_CLS);
    isPreset  = cmdValid && (cmd.op == srqp_pkg::CMD_STAT_PRESET);
    errEmpty  = (state_r.errCnt == '0);

    // limit condition from trace comparators
    limCondNew = 16'h0000;
    for (int t = 0; t < srqp_pkg::NUM_TRACES; t++) begin
      limCondNew[2*t]   = statIn.traceBelow[t];
      limCondNew[2*t+1] = statIn.traceAbove[t];
    end
    limCondNew = limCondNew & srqp_pkg::LIMIT_USED;
    limSummary = |(state_r.limEvt & state_r.limEn);

    // only two questionable bits exist here, bit 15 stays low
    quesCondNew = 16'h0000;
    quesCondNew[srqp_pkg::QUES_FREQ_BIT]  = statIn.freqQuestionable;
    quesCondNew[srqp_pkg::QUES_LIMIT_BIT] = limSummary;
    quesSummary = |(state_r.quesEvt & state_r.quesEn);

    state_nxt.limCond  = limCondNew;
    state_nxt.quesCond = quesCondNew;
    state_nxt.limEvt   = evtUpdate(state_r.limEvt, limCondNew, state_r.limCond,
                                   state_r.limPtr, state_r.limNtr,
                                   isCls || (cmdValid && cmd.op == srqp_pkg::CMD_LIM_EVT_RD));
    state_nxt.quesEvt  = evtUpdate(state_r.quesEvt, quesCondNew, state_r.quesCond,
                                   state_r.quesPtr, state_r.quesNtr,
                                   isCls || (cmdValid && cmd.op == srqp_pkg::CMD_QUES_EVT_RD));

    // event status register, opc waits for settings to finish
    if (isCls || (cmdValid && cmd.op == srqp_pkg::CMD_ESR_RD)) begin
      state_nxt.esr = srqp_pkg::BYTE_RESET;
    end
    if (cmdValid && cmd.op == srqp_pkg::CMD_OPC) begin
      state_nxt.opcPending = 1'b1;
    end else if (isCls) begin
      state_nxt.opcPending = 1'b0;
    end
    state_nxt.esr[7:1] = state_nxt.esr[7:1] | statIn.esrEvents;
    if (state_r.opcPending && statIn.settingsDone) begin
      state_nxt.esr[srqp_pkg::ESR_OPC_BIT] = 1'b1;
      state_nxt.opcPending = 1'b0;
    end
    esbSummary = |(state_r.esr & state_r.ese);

    // status byte summaries; bit 7 has no source here
    stbLow = srqp_pkg::BYTE_RESET;
    stbLow[srqp_pkg::STB_ERRQ_BIT] = !errEmpty;
    stbLow[srqp_pkg::STB_QUES_BIT] = quesSummary;
    stbLow[srqp_pkg::STB_MAV_BIT]  = statIn.messageAvailable;
    stbLow[srqp_pkg::STB_ESB_BIT]  = esbSummary;
    mss = |(stbLow & state_r.sre & srqp_pkg::STB_SRQ_MASK);
    stbLow[srqp_pkg::STB_MSS_BIT]  = mss;
    state_nxt.stb = stbLow;
    state_nxt.srq = mss;

    // parallel poll bit includes bit 6 of the status byte
    ist = |(state_r.ppe & state_r.stb);

    // error queue, full queue drops the newest entry
    doPop  = cmdValid && (cmd.op == srqp_pkg::CMD_ERR_RD) && !errEmpty;
    doPush = errPush && (state_r.errCnt != CNT_W'(ERRQ_DEPTH));
    if (doPush) begin
      state_nxt.errMem[state_r.errWr] = errCode;
      state_nxt.errWr = ptrInc(state_r.errWr);
    end
    if (doPop) begin
      state_nxt.errRd = ptrInc(state_r.errRd);
    end
    if (doPush && !doPop) begin
      state_nxt.errCnt = state_r.errCnt + CNT_W'(1);
    end else if (doPop && !doPush) begin
      state_nxt.errCnt = state_r.errCnt - CNT_W'(1);
    end
    if (isCls) begin
      state_nxt.errRd  = '0;
      state_nxt.errWr  = '0;
      state_nxt.errCnt = '0;
    end
    // full flag registered so the output comes straight from a flop
    state_nxt.errFull = (state_nxt.errCnt == CNT_W'(ERRQ_DEPTH));

    // register writes
    if (cmdValid) begin
      unique case (cmd.op)
        srqp_pkg::CMD_QUES_EN_WR:  state_nxt.quesEn  = cmd.data;
        srqp_pkg::CMD_QUES_PTR_WR: state_nxt.quesPtr = cmd.data;
        srqp_pkg::CMD_QUES_NTR_WR: state_nxt.quesNtr = cmd.data;
        srqp_pkg::CMD_LIM_EN_WR:   state_nxt.limEn   = cmd.data;
        srqp_pkg::CMD_LIM_PTR_WR:  state_nxt.limPtr  = cmd.data;
        srqp_pkg::CMD_LIM_NTR_WR:  state_nxt.limNtr  = cmd.data;
        srqp_pkg::CMD_SRE_WR:      state_nxt.sre     = cmd.data[7:0];
        srqp_pkg::CMD_ESE_WR:      state_nxt.ese     = cmd.data[7:0];
        srqp_pkg::CMD_PPE_WR:      state_nxt.ppe     = cmd.data[7:0];
        srqp_pkg::CMD_PP_CFG_WR:   state_nxt.ppCfg   = cmd.data[4:0];
        default: begin
        end
      endcase
    end
    if (isPreset) begin
      state_nxt.quesEn  = srqp_pkg::ENABLE_PRESET;
      state_nxt.limEn   = srqp_pkg::ENABLE_PRESET;
      state_nxt.quesPtr = srqp_pkg::PTR_PRESET;
      state_nxt.limPtr  = srqp_pkg::PTR_PRESET;
      state_nxt.quesNtr = srqp_pkg::NTR_PRESET;
      state_nxt.limNtr  = srqp_pkg::NTR_PRESET;
    end

    // query answers, one cycle after the command
    state_nxt.respValid = 1'b0;
    state_nxt.respData  = 16'h0000;
    if (cmdValid) begin
      unique case (cmd.op)
        srqp_pkg::CMD_QUES_COND_RD: state_nxt.respData = state_r.quesCond;
        srqp_pkg::CMD_QUES_EVT_RD:  state_nxt.respData = state_r.quesEvt;
        srqp_pkg::CMD_QUES_EN_RD:   state_nxt.respData = state_r.quesEn;
        srqp_pkg::CMD_LIM_COND_RD:  state_nxt.respData = state_r.limCond;
        srqp_pkg::CMD_LIM_EVT_RD:   state_nxt.respData = state_r.limEvt;
        srqp_pkg::CMD_LIM_EN_RD:    state_nxt.respData = state_r.limEn;
        srqp_pkg::CMD_SRE_RD:       state_nxt.respData = {8'h00, state_r.sre};
        srqp_pkg::CMD_ESE_RD:       state_nxt.respData = {8'h00, state_r.ese};
        srqp_pkg::CMD_ESR_RD:       state_nxt.respData = {8'h00, state_r.esr};
        srqp_pkg::CMD_STB_RD:       state_nxt.respData = {8'h00, state_r.stb};
        srqp_pkg::CMD_PPE_RD:       state_nxt.respData = {8'h00, state_r.ppe};
        srqp_pkg::CMD_IST_RD:       state_nxt.respData = {15'h0000, ist};
        srqp_pkg::CMD_ERR_RD: begin
          state_nxt.respData = errEmpty ? srqp_pkg::NO_ERROR_CODE
                                        : state_r.errMem[state_r.errRd];
        end
        default: begin
        end
      endcase
      unique case (cmd.op)
        srqp_pkg::CMD_QUES_COND_RD, srqp_pkg::CMD_QUES_EVT_RD, srqp_pkg::CMD_QUES_EN_RD,
        srqp_pkg::CMD_LIM_COND_RD, srqp_pkg::CMD_LIM_EVT_RD, srqp_pkg::CMD_LIM_EN_RD,
        srqp_pkg::CMD_SRE_RD, srqp_pkg::CMD_ESE_RD, srqp_pkg::CMD_ESR_RD,
        srqp_pkg::CMD_STB_RD, srqp_pkg::CMD_PPE_RD, srqp_pkg::CMD_IST_RD,
        srqp_pkg::CMD_ERR_RD: state_nxt.respValid = 1'b1;
        default: begin
        end
      endcase
    end

    // serial poll answer is the status byte query value
    state_nxt.spValid = serialPoll;
    state_nxt.spByte  = serialPoll ? state_r.stb : srqp_pkg::BYTE_RESET;

    // drive only the assigned line while the poll lasts
    state_nxt.ppDataOut = srqp_pkg::BYTE_RESET;
    state_nxt.ppDataOe  = srqp_pkg::BYTE_RESET;
    if (parallelPoll && state_r.ppCfg.enable) begin
      state_nxt.ppDataOe[state_r.ppCfg.line]  = 1'b1;
      state_nxt.ppDataOut[state_r.ppCfg.line] = ist ^ state_r.ppCfg.sense;
    end
  end

  // ***********************
  // registers
  // ***********************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r         <= '0;
      state_r.quesPtr <= srqp_pkg::PTR_PRESET;
      state_r.limPtr  <= srqp_pkg::PTR_PRESET;
      state_r.esr     <= srqp_pkg::ESR_RESET;
    end else if (clkEn) begin
      state_r <= state_nxt;
    end
  end

  assign respValid    = state_r.respValid;
  assign respData     = state_r.respData;
  assign srq          = state_r.srq;
  assign spValid      = state_r.spValid;
  assign spByte       = state_r.spByte;
  assign ppDataOut    = state_r.ppDataOut;
  assign ppDataOe     = state_r.ppDataOe;
  assign errQueueFull = state_r.errFull;

endmodule

// ==== verification/srqp_status_checker.sv ====
`timescale 1ns/10ps
module srqp_status_checker #(
  parameter int ERRQ_DEPTH = srqp_pkg::ERRQ_DEPTH_DEF
) (
  input wire logic                      core_clk,
  input wire logic                      rst_n,
  input wire logic                      clkEn,
  input wire logic                      cmdValid,
  input wire srqp_pkg::srqp_cmd_t       cmd,
  input wire srqp_pkg::srqp_status_in_t statIn,
  input wire logic                      errPush,
  input wire logic [15:0]               errCode,
  input wire logic                      serialPoll,
  input wire logic                      parallelPoll,
  input wire logic                      respValid,
  input wire logic [15:0]               respData,
  input wire logic                      srq,
  input wire logic                      spValid,
  input wire logic [7:0]                spByte,
  input wire logic [7:0]                ppDataOut,
  input wire logic [7:0]                ppDataOe,
  input wire logic                      errQueueFull
);
  // ********
  // decode
  // ********
  logic taken;
  logic isQry;
  logic isQues;
  logic isLim;
  logic isByte;
  logic isIst;
  always_comb begin
    taken  = cmdValid && clkEn;
    isQues = taken && (cmd.op inside {srqp_pkg::CMD_QUES_COND_RD, srqp_pkg::CMD_QUES_EVT_RD});
    isLim  = taken && (cmd.op inside {srqp_pkg::CMD_LIM_COND_RD, srqp_pkg::CMD_LIM_EVT_RD});
    isByte = taken && (cmd.op inside {srqp_pkg::CMD_SRE_RD, srqp_pkg::CMD_ESE_RD,
                                      srqp_pkg::CMD_ESR_RD, srqp_pkg::CMD_STB_RD,
                                      srqp_pkg::CMD_PPE_RD});
    isIst  = taken && (cmd.op == srqp_pkg::CMD_IST_RD);
    isQry  = isQues || isLim || isByte || isIst || (taken && (cmd.op inside
             {srqp_pkg::CMD_QUES_EN_RD, srqp_pkg::CMD_LIM_EN_RD, srqp_pkg::CMD_ERR_RD}));
  end
  // ********
  // checks
  // ********
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_query_answers: assert property (isQry |=> respValid)
    else $error("query not answered");
  a_write_silent: assert property (taken && !isQry |=> !respValid)
    else $error("write produced an answer");
  a_idle_zero: assert property (!respValid |-> respData == 16'h0000)
    else $error("answer data without valid");
  a_ques_bits: assert property (respValid && $past(isQues) |-> (respData & 16'hfddf) == 16'h0000)
    else $error("questionable word drives unsupported bits");
  a_limit_upper: assert property (respValid && $past(isLim) |-> respData[15:8] == 8'h00)
    else $error("limit word bits above 7 set");
  a_byte_width: assert property (respValid && $past(isByte) |-> respData[15:8] == 8'h00)
    else $error("byte register upper bits set");
  a_ist_single: assert property (respValid && $past(isIst) |-> respData[15:1] == 15'h0000)
    else $error("individual status not one bit");
  a_sp_follows: assert property (serialPoll && clkEn |=> spValid)
    else $error("serial poll not answered");
  a_pp_one_line: assert property ($onehot0(ppDataOe))
    else $error("more than one poll line driven");
  a_pp_release: assert property (!parallelPoll ##1 !parallelPoll |-> ppDataOe == 8'h00)
    else $error("poll line held outside a poll");
  a_freeze_hold: assert property (!clkEn |=> $stable(srq) && $stable(ppDataOe))
    else $error("state moved while frozen");
  c_srq_rise: cover property ($rose(srq));
  c_sp_seen: cover property (spValid);
  c_pp_drive: cover property (ppDataOe != 8'h00);
  c_queue_full: cover property (errQueueFull);
endmodule

bind srqp_status_core srqp_status_checker #(.ERRQ_DEPTH(ERRQ_DEPTH)) chk_i (
  .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .cmdValid(cmdValid), .cmd(cmd),
  .statIn(statIn), .errPush(errPush), .errCode(errCode), .serialPoll(serialPoll),
  .parallelPoll(parallelPoll), .respValid(respValid), .respData(respData), .srq(srq),
  .spValid(spValid), .spByte(spByte), .ppDataOut(ppDataOut), .ppDataOe(ppDataOe),
  .errQueueFull(errQueueFull));

// ==== verification/srqp_bus_ctrl_model.sv ====
`timescale 1ns/10ps
module srqp_bus_ctrl_model (
  input  wire logic [7:0] ppDataOut,
  input  wire logic [7:0] ppDataOe,
  output logic [7:0]      ppBus
);
  // lines nobody drives sink to the weak pull level, never keep a stale value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ppBus[i] = ppDataOe[i] ? ppDataOut[i] : 1'b0;
    end
  end
endmodule

// ==== verification/srqp_status_core_tb.sv ====
`timescale 1ns/10ps
module srqp_status_core_tb;
  // ********
  // signals
  // ********
  localparam int DEPTH = 4;
  logic                      core_clk;
  logic                      rst_n;
  logic                      clkEn;
  logic                      cmdValid;
  srqp_pkg::srqp_cmd_t       cmd;
  srqp_pkg::srqp_status_in_t statIn;
  logic                      errPush;
  logic [15:0]               errCode;
  logic                      serialPoll;
  logic                      parallelPoll;
  logic                      respValid;
  logic [15:0]               respData;
  logic                      srq;
  logic                      spValid;
  logic [7:0]                spByte;
  logic [7:0]                ppDataOut;
  logic [7:0]                ppDataOe;
  logic                      errQueueFull;
  logic [7:0]                ppBus;
  int                        errorCnt;
  int                        checked;
  int                        cycles;
  srqp_status_core #(.ERRQ_DEPTH(DEPTH)) DUT (.core_clk(core_clk), .rst_n(rst_n),
    .clkEn(clkEn), .cmdValid(cmdValid), .cmd(cmd), .statIn(statIn), .errPush(errPush),
    .errCode(errCode), .serialPoll(serialPoll), .parallelPoll(parallelPoll),
    .respValid(respValid), .respData(respData), .srq(srq), .spValid(spValid),
    .spByte(spByte), .ppDataOut(ppDataOut), .ppDataOe(ppDataOe),
    .errQueueFull(errQueueFull));
  srqp_bus_ctrl_model ctrl (.ppDataOut(ppDataOut), .ppDataOe(ppDataOe), .ppBus(ppBus));
  // ********
  // tasks
  // ********
  task automatic closeOut();
    if (errorCnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // one idle edge after each command, so calls never collide on the strobe
  task automatic issue(input srqp_pkg::srqp_cmd_op_t op, input logic [15:0] d);
    cmdValid = 1'b1;
    cmd = '{op, d};
    tick(1);
    cmdValid = 1'b0;
    tick(1);
  endtask
  // answer stands only between the taking edge and the next one
  task automatic query(input srqp_pkg::srqp_cmd_op_t op, input logic [15:0] exp);
    cmdValid = 1'b1;
    cmd = '{op, 16'h0000};
    tick(1);
    cmdValid = 1'b0;
    chk({15'h0000, respValid}, 16'h0001);
    chk(respData, exp);
    tick(1);
  endtask
  // ********
  // clock and guard
  // ********
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errorCnt++;
      $display("[FAIL] %0t run hung", $time);
      closeOut();
    end
  end
  // ********
  // tests
  // ********
  initial begin
    {rst_n, cmdValid, errPush, serialPoll, parallelPoll} = 5'h00;
    clkEn = 1'b1;
    cmd = '{srqp_pkg::CMD_NOP, 16'h0000};
    statIn = '0;
    errCode = 16'h0000;
    errorCnt = 0;
    checked = 0;
    cycles = 0;
    repeat (12) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    clkEn = 1'b0;
    tick(3);
    clkEn = 1'b1;
    query(srqp_pkg::CMD_ESR_RD, 16'h0080);
    query(srqp_pkg::CMD_ESR_RD, 16'h0000);
    query(srqp_pkg::CMD_ERR_RD, 16'h0000);
    statIn.freqQuestionable = 1'b1;
    tick(4);
    query(srqp_pkg::CMD_QUES_COND_RD, 16'h0020);
    query(srqp_pkg::CMD_QUES_EVT_RD, 16'h0020);
    query(srqp_pkg::CMD_QUES_EVT_RD, 16'h0000);
    issue(srqp_pkg::CMD_LIM_EN_WR, 16'hffff);
    issue(srqp_pkg::CMD_QUES_EN_WR, 16'hffff);
    statIn.traceBelow = 4'b0101;
    statIn.traceAbove = 4'b1010;
    tick(6);
    query(srqp_pkg::CMD_LIM_COND_RD, 16'h0099);
    query(srqp_pkg::CMD_QUES_COND_RD, 16'h0220);
    query(srqp_pkg::CMD_LIM_EVT_RD, 16'h0099);
    issue(srqp_pkg::CMD_SRE_WR, 16'h00ff);
    tick(3);
    chk({15'h0000, srq}, 16'h0001);
    query(srqp_pkg::CMD_STB_RD, 16'h0048);
    serialPoll = 1'b1;
    tick(1);
    serialPoll = 1'b0;
    chk({7'h00, spValid, spByte}, 16'h0148);
    issue(srqp_pkg::CMD_PPE_WR, 16'h0008);
    issue(srqp_pkg::CMD_PP_CFG_WR, 16'h001b);
    parallelPoll = 1'b1;
    tick(3);
    chk({ppDataOe, ppBus}, 16'h0800);
    parallelPoll = 1'b0;
    tick(2);
    issue(srqp_pkg::CMD_PPE_WR, 16'h0040);
    issue(srqp_pkg::CMD_PP_CFG_WR, 16'h0015);
    parallelPoll = 1'b1;
    tick(3);
    chk({ppDataOe, ppBus}, 16'h2020);
    parallelPoll = 1'b0;
    tick(2);
    query(srqp_pkg::CMD_IST_RD, 16'h0001);
    issue(srqp_pkg::CMD_SRE_WR, 16'h0000);
    tick(3);
    chk({15'h0000, srq}, 16'h0000);
    issue(srqp_pkg::CMD_CLS, 16'h0000);
    query(srqp_pkg::CMD_QUES_EVT_RD, 16'h0000);
    query(srqp_pkg::CMD_STB_RD, 16'h0000);
    issue(srqp_pkg::CMD_ESE_WR, 16'h00ff);
    issue(srqp_pkg::CMD_SRE_WR, 16'h00ff);
    issue(srqp_pkg::CMD_OPC, 16'h0000);
    tick(3);
    chk({15'h0000, srq}, 16'h0000);
    statIn.settingsDone = 1'b1;
    tick(4);
    chk({15'h0000, srq}, 16'h0001);
    statIn.settingsDone = 1'b0;
    query(srqp_pkg::CMD_ESR_RD, 16'h0001);
    query(srqp_pkg::CMD_SRE_RD, 16'h00ff);
    query(srqp_pkg::CMD_ESE_RD, 16'h00ff);
    query(srqp_pkg::CMD_PPE_RD, 16'h0040);
    statIn.messageAvailable = 1'b1;
    tick(3);
    query(srqp_pkg::CMD_STB_RD, 16'h0050);
    statIn.messageAvailable = 1'b0;
    statIn.esrEvents = 7'h10;
    tick(1);
    statIn.esrEvents = 7'h00;
    query(srqp_pkg::CMD_ESR_RD, 16'h0020);
    // back-to-back pushes, the last one meets a full queue and is lost
    errPush = 1'b1;
    for (int i = 0; i <= DEPTH; i++) begin
      errCode = 16'h0100 + 16'(i);
      tick(1);
    end
    errPush = 1'b0;
    chk({15'h0000, errQueueFull}, 16'h0001);
    query(srqp_pkg::CMD_STB_RD, 16'h0044);
    for (int i = 0; i < DEPTH; i++) begin
      query(srqp_pkg::CMD_ERR_RD, 16'h0100 + 16'(i));
    end
    query(srqp_pkg::CMD_ERR_RD, 16'h0000);
    errPush = 1'b1;
    tick(1);
    errPush = 1'b0;
    issue(srqp_pkg::CMD_CLS, 16'h0000);
    query(srqp_pkg::CMD_ERR_RD, 16'h0000);
    issue(srqp_pkg::CMD_QUES_PTR_WR, 16'h0000);
    issue(srqp_pkg::CMD_STAT_PRESET, 16'h0000);
    query(srqp_pkg::CMD_QUES_EN_RD, 16'h0000);
    query(srqp_pkg::CMD_LIM_EN_RD, 16'h0000);
    statIn.freqQuestionable = 1'b0;
    tick(3);
    statIn.freqQuestionable = 1'b1;
    tick(4);
    query(srqp_pkg::CMD_QUES_EVT_RD, 16'h0020);
    closeOut();
  end
endmodule
